// [common/pc_stack_params.svh]
// Constants for the program counter and return stack.
`ifndef PC_STACK_PARAMS_SVH
`define PC_STACK_PARAMS_SVH
`define PC_WIDTH        10
`define PC_UPPER_LSB    8
`define PC_RESET_VALUE  10'h000
`define PC_STEP         10'h001
`define STACK_DEPTH     8
`define STACK_PTR_WIDTH 3
`define PMEM_WORDS      1024
`define PMEM_WIDTH      13
`define OP_WIDTH        4
`define PHASE_FIRST     1'b0
`define PHASE_LAST      1'b1
`endif

// [common/pc_stack_pkg.sv]
// Types for the program counter and return stack.
`include "pc_stack_params.svh"
package pc_stack_pkg;
    typedef logic [`PC_WIDTH-1:0] pc_t;
    typedef enum logic [`OP_WIDTH-1:0] {
        OP_NONE, OP_DIRECT_JUMP, OP_CALL, OP_RETURN, OP_RETURN_LITERAL,
        OP_RETURN_INTERRUPT, OP_RELATIVE_ADD, OP_LOW_BYTE_LOAD,
        OP_REG_WRITE, OP_LONG_CALL, OP_LONG_JUMP
    } pc_op_e;
    typedef struct packed {
        pc_op_e   op;
        pc_t      target;
        logic [7:0] data;
    } pc_cmd_s;
endpackage : pc_stack_pkg

// [hw/return_stack_mem.sv]
// Small memory holding the return-stack entries.
`timescale 1ns/1ps
`include "pc_stack_params.svh"
module return_stack_mem (
    input  wire logic                          clk_in,      // System clock.
    input  wire logic                          wr_en_in,    // Write strobe.
    input  wire logic [`STACK_PTR_WIDTH-1:0]   wr_addr_in,  // Write slot.
    input  wire logic [`PC_WIDTH-1:0]          wr_data_in,  // Return address.
    input  wire logic [`STACK_PTR_WIDTH-1:0]   rd_addr_in,  // Read slot.
    output logic      [`PC_WIDTH-1:0]          rd_data_out  // Registered read data.
);
    logic [`PC_WIDTH-1:0] mem_ff [`STACK_DEPTH];

    // Write port and registered read port.
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_ff[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_ff[rd_addr_in];
    end
endmodule : return_stack_mem

// [hw/program_counter_stack.sv]
// Program counter with eight-level hardware return stack.
`timescale 1ns/1ps
`include "pc_stack_params.svh"
module program_counter_stack (
    input  wire logic                     CLK_IN,        // System clock, 40 MHz.
    input  wire logic                     ARST_N_IN,     // Asynchronous reset, active low.
    input  wire pc_stack_pkg::pc_cmd_s    CMD_IN,        // Decoded instruction, sampled at phase end.
    input  wire logic [`PMEM_WIDTH-1:0]   PMEM_DATA_IN,  // Program word read back.
    output logic      [`PC_WIDTH-1:0]     PMEM_ADDR_OUT, // Program memory address.
    output logic                          PHASE_OUT,     // High on the last clock of a cycle.
    output logic                          SECOND_WORD_OUT, // High while a long op fetches word 2.
    output logic      [`STACK_PTR_WIDTH-1:0] STACK_PTR_OUT // Next free stack slot.
);
    logic [`PC_WIDTH-1:0] pc_ff;
    logic [`PC_WIDTH-1:0] nxt_pc;
    logic                 phase_ff;
    logic                 second_ff;
    pc_stack_pkg::pc_op_e long_op_ff;
    logic [`STACK_PTR_WIDTH-1:0] sp_ff;
    logic [`PC_WIDTH-1:0] top_data;
    logic                 push;
    logic                 pop;
    logic [`PC_WIDTH-1:0] push_data;
    logic                 cycle_end;
    pc_stack_pkg::pc_op_e op;

    // Increment within the single 1024-word page; wraps at the page end.
    function automatic logic [`PC_WIDTH-1:0] pc_inc(input logic [`PC_WIDTH-1:0] v);
        pc_inc = v + `PC_STEP;
    endfunction : pc_inc

    assign op        = CMD_IN.op;
    assign cycle_end = (phase_ff == `PHASE_LAST);
    assign pop       = cycle_end && !second_ff &&
                       (op == pc_stack_pkg::OP_RETURN || op == pc_stack_pkg::OP_RETURN_LITERAL ||
                        op == pc_stack_pkg::OP_RETURN_INTERRUPT);
    assign push      = cycle_end && ((!second_ff && op == pc_stack_pkg::OP_CALL) ||
                       (second_ff && long_op_ff == pc_stack_pkg::OP_LONG_CALL));
    assign push_data = pc_inc(pc_ff);

    // Stack storage; the top entry is read from the slot below the pointer.
    return_stack_mem u_stack (
        .clk_in      (CLK_IN),
        .wr_en_in    (push),
        .wr_addr_in  (sp_ff),
        .wr_data_in  (push_data),
        .rd_addr_in  (sp_ff - 3'h1),
        .rd_data_out (top_data)
    );

    // Two clocks per instruction cycle.
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            phase_ff <= `PHASE_FIRST;
        end else begin
            phase_ff <= ~phase_ff;
        end
    end

    // Long ops hold a second instruction cycle to fetch the target word.
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            second_ff  <= 1'b0;
            long_op_ff <= pc_stack_pkg::OP_NONE;
        end else if (cycle_end) begin
            if (!second_ff && (op == pc_stack_pkg::OP_LONG_CALL ||
                               op == pc_stack_pkg::OP_LONG_JUMP)) begin
                second_ff  <= 1'b1;
                long_op_ff <= op;
            end else begin
                second_ff  <= 1'b0;
                long_op_ff <= pc_stack_pkg::OP_NONE;
            end
        end
    end

    // Stack pointer wraps around the eight slots.
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            sp_ff <= '0;
        end else if (push) begin
            sp_ff <= sp_ff + 3'h1;
        end else if (pop) begin
            sp_ff <= sp_ff - 3'h1;
        end
    end

    // Next counter value chosen by the decoded operation.
    always_comb begin
        nxt_pc = pc_ff;
        if (cycle_end) begin
            if (second_ff) begin
                nxt_pc = PMEM_DATA_IN[`PC_WIDTH-1:0];
            end else begin
                case (op)
                    pc_stack_pkg::OP_DIRECT_JUMP,
                    pc_stack_pkg::OP_CALL: begin
                        nxt_pc = CMD_IN.target;
                    end
                    pc_stack_pkg::OP_RETURN,
                    pc_stack_pkg::OP_RETURN_LITERAL,
                    pc_stack_pkg::OP_RETURN_INTERRUPT: begin
                        nxt_pc = top_data;
                    end
                    pc_stack_pkg::OP_RELATIVE_ADD: begin
                        nxt_pc = pc_ff + {2'b00, CMD_IN.data};
                    end
                    pc_stack_pkg::OP_LOW_BYTE_LOAD,
                    pc_stack_pkg::OP_REG_WRITE: begin
                        nxt_pc = {pc_ff[`PC_WIDTH-1:`PC_UPPER_LSB], CMD_IN.data};
                    end
                    default: begin
                        nxt_pc = pc_inc(pc_ff);
                    end
                endcase
            end
        end
    end

    // Program counter register, cleared on reset.
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pc_ff <= `PC_RESET_VALUE;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    assign PMEM_ADDR_OUT   = pc_ff;
    assign PHASE_OUT       = phase_ff;
    assign SECOND_WORD_OUT = second_ff;
    assign STACK_PTR_OUT   = sp_ff;

    // While reset is low the counter, phase, flag and pointer sit at their cleared values.
    a_pc_reset_zero: assert property (
        @(posedge CLK_IN)
        !ARST_N_IN |->
        pc_ff == `PC_RESET_VALUE && sp_ff == '0 && phase_ff == `PHASE_FIRST && !second_ff
    ) else $error("Reset state not cleared.");

    // A direct jump and a call load the address field at the end of the cycle.
    a_jump_loads: assert property (
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        cycle_end && !second_ff && op == pc_stack_pkg::OP_DIRECT_JUMP
        |=> pc_ff == $past(CMD_IN.target)
    ) else $error("Jump target not loaded.");
    a_call_target: assert property (
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        cycle_end && !second_ff && op == pc_stack_pkg::OP_CALL
        |=> pc_ff == $past(CMD_IN.target)
    ) else $error("Call target not loaded.");
    a_call_pushes: assert property (
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        cycle_end && !second_ff && op == pc_stack_pkg::OP_CALL
        |=> sp_ff == $past(sp_ff) + 3'h1
    ) else $error("Call did not push.");

    // A return of any kind loads the registered top entry and drops the pointer.
    a_return_pops: assert property (
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        pop
        |=> pc_ff == $past(top_data) && sp_ff == $past(sp_ff) - 3'h1
    ) else $error("Return did not load top.");

    // Register writes: the add carries across the byte, the loads keep the upper bits.
    a_add_full: assert property (
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        cycle_end && !second_ff && op == pc_stack_pkg::OP_RELATIVE_ADD
        |=> pc_ff == $past(pc_ff) + {2'h0, $past(CMD_IN.data)}
    ) else $error("Add wrong.");
    a_low_load_keep: assert property (
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        cycle_end && !second_ff && op == pc_stack_pkg::OP_LOW_BYTE_LOAD
        |=> pc_ff == {$past(pc_ff[`PC_WIDTH-1:`PC_UPPER_LSB]), $past(CMD_IN.data)}
    ) else $error("Low byte load wrong.");
    a_write_keep: assert property (
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        cycle_end && !second_ff && op == pc_stack_pkg::OP_REG_WRITE
        |=> pc_ff == {$past(pc_ff[`PC_WIDTH-1:`PC_UPPER_LSB]), $past(CMD_IN.data)}
    ) else $error("Register write wrong.");

    // Cycle timing: two clocks per cycle, a second cycle for the long ops.
    a_phase_toggle: assert property (
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        !phase_ff |=> phase_ff ##1 !phase_ff
    ) else $error("Phase stuck.");
    a_long_two_cycles: assert property (
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        cycle_end && !second_ff &&
        (op == pc_stack_pkg::OP_LONG_JUMP || op == pc_stack_pkg::OP_LONG_CALL)
        |=> second_ff [*2] ##1 !second_ff
    ) else $error("Long op length wrong.");

    // The second word of a long op supplies the whole target; a long call pushes.
    a_long_target: assert property (
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        cycle_end && second_ff
        |=> pc_ff == $past(PMEM_DATA_IN[`PC_WIDTH-1:0])
    ) else $error("Long target not loaded.");
    a_long_call_push: assert property (
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        cycle_end && second_ff && long_op_ff == pc_stack_pkg::OP_LONG_CALL
        |=> sp_ff == $past(sp_ff) + 3'h1
    ) else $error("Long call did not push.");

    // The counter only moves at the end of an instruction cycle.
    a_pc_hold_first: assert property (
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        !cycle_end |=> $stable(pc_ff)
    ) else $error("Counter moved mid-cycle.");

    // Main scenarios: call, return, long op and low byte load.
    c_call: cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN) push);
    c_ret: cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN) pop);
    c_long: cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN) second_ff && cycle_end);
    c_low_load: cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        cycle_end && !second_ff && op == pc_stack_pkg::OP_LOW_BYTE_LOAD);
endmodule : program_counter_stack

// [test/pmem_model.sv]
// Program memory model that answers each fetch address with a fixed word.
`timescale 1ns/1ps
`include "pc_stack_params.svh"
module pmem_model (
    input  wire logic [`PC_WIDTH-1:0]   addr_in,  // Fetch address.
    output logic      [`PMEM_WIDTH-1:0] data_out  // Program word.
);
    // One page of 1024 words of 13 bits, each a pattern of its own address.
    assign data_out = {3'h5, addr_in ^ 10'h2A5};
endmodule : pmem_model

// [test/tb_top.sv]
// Self-checking bench for the program counter and return stack.
`timescale 1ns/1ps
`include "pc_stack_params.svh"
module tb_top;
    logic                  clk, arst_n, phase, second;
    logic [2:0]            sp, exp_sp;
    logic [12:0]           pdata;
    pc_stack_pkg::pc_t     addr, exp_pc;
    pc_stack_pkg::pc_t     stk [8];
    pc_stack_pkg::pc_cmd_s cmd;
    int                    err_count, n_checks, seed;
    program_counter_stack u_dut (.CLK_IN(clk), .ARST_N_IN(arst_n), .CMD_IN(cmd),
        .PMEM_DATA_IN(pdata), .PMEM_ADDR_OUT(addr), .PHASE_OUT(phase),
        .SECOND_WORD_OUT(second), .STACK_PTR_OUT(sp));
    pmem_model u_mem (.addr_in(addr), .data_out(pdata));
    // Free-running 40 MHz clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Compares a seen value with the expected one and counts the outcome.
    task automatic chk(input string nm, input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    // Target that the memory model holds in the second word of a long op.
    function automatic pc_stack_pkg::pc_t word2(input pc_stack_pkg::pc_t a);
        return a ^ 10'h2A5;
    endfunction : word2
    // Holds reset for 8 cycles, then checks and clears the expected state.
    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk("pc after reset", addr, `PC_RESET_VALUE);
        chk("sp after reset", {7'h00, sp}, 10'h000);
        chk("phase after reset", {9'h000, phase}, {9'h000, `PHASE_FIRST});
        chk("second word after reset", {9'h000, second}, 10'h000);
        exp_pc = `PC_RESET_VALUE;
        exp_sp = 3'h0;
    endtask : do_reset
    // Hands one command over on the edge before its accepting edge and checks the outcome.
    task automatic issue(input logic [3:0] o, input pc_stack_pkg::pc_t t, input logic [7:0] d);
        int n;
        logic lng;
        pc_stack_pkg::pc_t nxt;
        n = 0;
        while ((phase !== 1'b0 || second !== 1'b0) && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (n >= 8) begin
            err_count++;
            close_out();
        end
        @(posedge clk);
        cmd <= '{pc_stack_pkg::pc_op_e'(o), t, d};
        nxt = exp_pc + `PC_STEP;
        lng = (o == 4'h9 || o == 4'hA);
        case (pc_stack_pkg::pc_op_e'(o))
            pc_stack_pkg::OP_DIRECT_JUMP: nxt = t;
            pc_stack_pkg::OP_CALL, pc_stack_pkg::OP_LONG_CALL: begin
                stk[exp_sp] = lng ? exp_pc + 10'h002 : exp_pc + 10'h001;
                exp_sp = exp_sp + 3'h1;
                nxt = lng ? word2(exp_pc + 10'h001) : t;
            end
            pc_stack_pkg::OP_RETURN, pc_stack_pkg::OP_RETURN_LITERAL,
            pc_stack_pkg::OP_RETURN_INTERRUPT: begin
                exp_sp = exp_sp - 3'h1;
                nxt = stk[exp_sp];
            end
            pc_stack_pkg::OP_RELATIVE_ADD: nxt = exp_pc + {2'h0, d};
            pc_stack_pkg::OP_LOW_BYTE_LOAD, pc_stack_pkg::OP_REG_WRITE: nxt = {exp_pc[9:8], d};
            pc_stack_pkg::OP_LONG_JUMP: nxt = word2(exp_pc + 10'h001);
            default: ;
        endcase
        @(posedge clk);
        @(negedge clk);
        chk("second word flag", {9'h000, second}, {9'h000, lng});
        chk("phase after accept", {9'h000, phase}, {9'h000, `PHASE_FIRST});
        if (lng) begin
            chk("second word address", addr, exp_pc + `PC_STEP);
            repeat (2) @(posedge clk);
            @(negedge clk);
        end
        chk("program counter", addr, nxt);
        chk("stack pointer", {7'h00, sp}, {7'h00, exp_sp});
        exp_pc = nxt;
    endtask : issue
    // Issues a run of random commands covering every operation code.
    task automatic run_random(input int cnt);
        for (int i = 0; i < cnt; i++) begin
            issue(4'({$random(seed)} % 11), 10'($random(seed)), 8'($random(seed)));
        end
    endtask : run_random
    // Corner cases first, then random traffic, a reset in mid-run and more traffic.
    initial begin
        seed = 92721;
        err_count = 0;
        n_checks = 0;
        arst_n = 1'b0;
        cmd = '0;
        do_reset();
        issue(pc_stack_pkg::OP_DIRECT_JUMP, 10'h3FF, 8'h00);
        issue(pc_stack_pkg::OP_NONE, 10'h000, 8'h00);
        issue(pc_stack_pkg::OP_DIRECT_JUMP, 10'h2FE, 8'h00);
        issue(pc_stack_pkg::OP_RELATIVE_ADD, 10'h000, 8'h05);
        issue(pc_stack_pkg::OP_LOW_BYTE_LOAD, 10'h000, 8'h00);
        issue(pc_stack_pkg::OP_REG_WRITE, 10'h000, 8'hAA);
        for (int i = 0; i < 9; i++) issue(pc_stack_pkg::OP_CALL, 10'(i * 113), 8'h00);
        for (int i = 0; i < 9; i++) issue(pc_stack_pkg::OP_RETURN, 10'h000, 8'h00);
        issue(pc_stack_pkg::OP_LONG_CALL, 10'h000, 8'h00);
        issue(pc_stack_pkg::OP_LONG_JUMP, 10'h000, 8'h00);
        run_random(300);
        do_reset();
        run_random(60);
        close_out();
    end
endmodule : tb_top
